/* File: hv_far_side.sv */
// Far-side model: wake bus with its pull-down, bus pins and analog detectors.
// Assumes the bench sets the fault knobs; combinational, no clock needed.
`timescale 1ns/1ns
module hv_far_side (
  input wire hv_pkg::hv_drive_s drive,
  input wire logic [3:0] fault,
  input wire logic gnd_short,
  input wire logic ext_en,
  input wire logic ext_lvl,
  output hv_pkg::hv_sense_s sense
);
  import hv_pkg::*;
  logic wake_lvl;
  // Released bus falls to the pull-down, never holds the last value
  assign wake_lvl = drive.wake_oe ? (drive.wake_out & ~gnd_short) : (ext_en & ext_lvl);
  // Short detectors only see current while their driver is on
  always_comb begin
    sense.supply_low = fault[3];
    sense.thermal = fault[2];
    sense.serial_short = fault[1] & drive.serial_en;
    sense.second_short = fault[0] & drive.second_en;
    sense.wake_overcurrent = drive.wake_oe & drive.wake_out & gnd_short;
    sense.wake_in = wake_lvl;
  end
endmodule

/* File: hv_pkg.sv */
// Constants, field positions and carrier types for the high-voltage status block.
// Assumes a single 250 MHz clock; shared by the design and its testbench.
package hv_pkg;
  // Clock rate and documented times
  localparam int CLK_MHZ = 250;
  localparam int XFER_US = 10;
  localparam int XFER_CYC = XFER_US * CLK_MHZ;
  localparam logic [11:0] XFER_LAST = 12'(XFER_CYC - 1);
  localparam int OC_US = 400;
  localparam int unsigned OC_CYC = OC_US * CLK_MHZ;
  localparam int MONO_MS = 1300;
  localparam int unsigned MONO_CYC = MONO_MS * CLK_MHZ * 1000;

  // Event flag positions
  localparam int FL_SUPPLY = 5;
  localparam int FL_WAKE_REQ = 4;
  localparam int FL_OVERTEMP = 3;
  localparam int FL_SERIAL_SC = 2;
  localparam int FL_SECOND_SC = 1;
  localparam int FL_WAKE_SC = 0;

  // Live state positions
  localparam int LV_WAKE_PIN = 7;
  localparam int LV_OVERTEMP = 6;
  localparam int LV_SERIAL_SC = 2;
  localparam int LV_SECOND_SC = 1;
  localparam int LV_WAKE_SC = 0;

  // Configuration bit positions
  localparam int CA_SUPPLY_EN = 3;
  localparam int CA_WAKE_ASSERT = 4;
  localparam int CB_MONO_OFF = 1;
  localparam int CB_REENABLE = 3;
  localparam int CB_WAKE_IO = 4;

  // Command status positions
  localparam int ST_BUSY = 0;
  localparam int ST_OK = 1;

  // Values after reset
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;

  // Commands written to the command port
  localparam logic [7:0] CMD_RD_FLAGS = 8'h01;
  localparam logic [7:0] CMD_RD_LIVE = 8'h02;
  localparam logic [7:0] CMD_RD_CFGA = 8'h03;
  localparam logic [7:0] CMD_RD_CFGB = 8'h04;
  localparam logic [7:0] CMD_WR_CFGA = 8'h83;
  localparam logic [7:0] CMD_WR_CFGB = 8'h84;

  typedef enum logic [1:0] {XF_IDLE, XF_AUTO, XF_READ, XF_WRITE} xfer_e;

  // Analog detector outputs and the sensed wake pin
  typedef struct packed {
    logic supply_low;
    logic thermal;
    logic serial_short;
    logic second_short;
    logic wake_overcurrent;
    logic wake_in;
  } hv_sense_s;

  // Driver controls toward the high-voltage pins
  typedef struct packed {
    logic serial_en;
    logic second_en;
    logic wake_out;
    logic wake_oe;
  } hv_drive_s;
endpackage

/* File: hv_status_wake.sv */
// High-voltage event flags, indirect command/data port and wake pin control.
// Assumes detector inputs and the wake pin are asynchronous; command port is on clk.
// Functional notes
// RULE1 - An interrupt event copies the event flags into the data port automatically.
// RULE2 - Flag bit 5 shows supply below 6.0 V, only when enabled, never latched.
// RULE3 - In wake input mode, a wake pin edge sets flag bit 4.
// RULE4 - Flag bit 3 is set after a thermal shutdown event.
// RULE5 - Thermal shutdown disables serial, second bus and wake drivers.
// RULE6 - Serial bus short sets flag bit 2, disables its driver; read clears it.
// RULE7 - Second bus short sets flag bit 1; read clears it.
// RULE8 - Wake pin short sets flag bit 0.
// RULE9 - Software ignores the two top flag bits; they read zero.
// RULE10 - Wake pin defaults to output, driven high by config A bit 4.
// RULE11 - Wake output changes only after the 10 us transfer latency.
// RULE12 - Monoflop releases the asserted wake driver after 1.3 seconds.
// RULE13 - Config B bit 1 disables the monoflop timeout.
// RULE14 - With monoflop off, software releases the wake driver within 1.3 s.
// RULE15 - Wake overcurrent for 400 us raises an interrupt and sets live bit 0.
// RULE16 - Software re-enables drivers after thermal event via config B bit 3.
// RULE17 - Config B bit 4 set puts the wake pin into input/output mode.
// RULE18 - In input mode any wake pin edge raises an interrupt at once.
// RULE19 - In input mode live bit 7 follows the wake pin level.
// RULE20 - Busy bit stays set for the 10 us transfer, then ok bit is checked.
`timescale 1ns/1ns
module hv_status_wake #(
  parameter int unsigned MONO_CYCLES = hv_pkg::MONO_CYC,
  parameter int unsigned OC_CYCLES = hv_pkg::OC_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cmd_wr,
  input wire logic [7:0] cmd_wdata,
  input wire logic dat_wr,
  input wire logic [7:0] dat_wdata,
  output logic [7:0] cmd_status,
  output logic [7:0] dat_rdata,
  input wire hv_pkg::hv_sense_s sense,
  output hv_pkg::hv_drive_s drive,
  output logic hv_irq
);
  import hv_pkg::*;

  hv_sense_s s1_q, s2_q, s3_q, st_q, prv_q;
  logic [7:0] cfg_a_q, cfg_b_q, flags_q, live_q;
  logic [7:0] flags_view, live_view, set_v, clr_v, xbuf_q, wbuf_q, rdata_q, xcmd_q;
  logic ser_en_q, sec_en_q, wake_en_q, timeout_q, ok_q, pend_q, irq_q;
  logic [31:0] mono_cnt_q, oc_cnt_q;
  logic [11:0] xcnt_q;
  xfer_e xs_q;
  hv_drive_s drv_q;
  logic wake_on, th_ev, ser_ev, sec_ev, sup_ev, wk_ev, oc_ev, irq_ev;
  logic done, apply_a, apply_b, start_auto, start_cmd, cmd_known;

  // Three-stage synchroniser; a bit moves only when stages two and three agree
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
      prv_q <= '0;
    end else begin
      s1_q <= sense;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= hv_sense_s'((s2_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q)));
      prv_q <= st_q;
    end
  end

  // Detector events taken on the filtered levels
  assign th_ev = st_q.thermal & ~prv_q.thermal;
  assign ser_ev = st_q.serial_short & ~prv_q.serial_short;
  assign sec_ev = st_q.second_short & ~prv_q.second_short;
  assign sup_ev = cfg_a_q[CA_SUPPLY_EN] & st_q.supply_low & ~prv_q.supply_low;
  assign wk_ev = cfg_b_q[CB_WAKE_IO] & (st_q.wake_in ^ prv_q.wake_in); // RULE18
  assign oc_ev = wake_on & st_q.wake_overcurrent & (oc_cnt_q == OC_CYCLES - 1); // RULE15
  assign irq_ev = th_ev | ser_ev | sec_ev | sup_ev | wk_ev | oc_ev;

  // Interrupt pulse toward the core, one cycle per event cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= irq_ev; // RULE18
    end
  end
  assign hv_irq = irq_q;

  // Supply bit is live, top two bits read zero
  always_comb begin
    flags_view = {2'b00, 1'b0, flags_q[4:0]}; // RULE9
    flags_view[FL_SUPPLY] = cfg_a_q[CA_SUPPLY_EN] & st_q.supply_low; // RULE2
    live_view = live_q;
    live_view[LV_WAKE_PIN] = cfg_b_q[CB_WAKE_IO] & st_q.wake_in; // RULE19
  end

  // Sticky flag sources
  always_comb begin
    set_v = 8'h00;
    set_v[FL_WAKE_REQ] = wk_ev; // RULE3
    set_v[FL_OVERTEMP] = th_ev; // RULE4
    set_v[FL_SERIAL_SC] = ser_ev; // RULE6
    set_v[FL_SECOND_SC] = sec_ev; // RULE7
    set_v[FL_WAKE_SC] = oc_ev; // RULE8
  end

  // Auto load starts one cycle after the event, so the snapshot already holds its flag
  assign start_auto = (xs_q == XF_IDLE) & pend_q; // RULE1
  assign cmd_known = (cmd_wdata == CMD_RD_FLAGS) | (cmd_wdata == CMD_RD_LIVE) | (cmd_wdata == CMD_RD_CFGA) |
                     (cmd_wdata == CMD_RD_CFGB) | (cmd_wdata == CMD_WR_CFGA) | (cmd_wdata == CMD_WR_CFGB);
  assign start_cmd = (xs_q == XF_IDLE) & ~start_auto & cmd_wr & cmd_known;
  assign clr_v = (start_auto | (start_cmd & (cmd_wdata == CMD_RD_FLAGS))) ? flags_view : 8'h00; // RULE6 RULE7

  // Flags: a set in the clearing cycle is kept
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= ((flags_q & ~clr_v) | set_v) & 8'h1F;
    end
  end

  // Transfer engine behind the command/data pair
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      xs_q <= XF_IDLE;
      xcnt_q <= 12'h000;
      xbuf_q <= 8'h00;
      xcmd_q <= 8'h00;
    end else begin
      case (xs_q)
        XF_IDLE: begin
          xcnt_q <= 12'h000;
          if (start_auto) begin
            xs_q <= XF_AUTO;
            xbuf_q <= flags_view; // RULE1
          end else if (start_cmd) begin
            xcmd_q <= cmd_wdata;
            if (cmd_wdata[7]) begin
              xs_q <= XF_WRITE;
            end else begin
              xs_q <= XF_READ;
            end
            case (cmd_wdata)
              CMD_RD_FLAGS: xbuf_q <= flags_view;
              CMD_RD_LIVE: xbuf_q <= live_view;
              CMD_RD_CFGA: xbuf_q <= cfg_a_q;
              CMD_RD_CFGB: xbuf_q <= cfg_b_q;
              default: xbuf_q <= wbuf_q;
            endcase
          end
        end
        XF_AUTO, XF_READ, XF_WRITE: begin
          if (xcnt_q == XFER_LAST) begin
            xs_q <= XF_IDLE; // RULE20
          end else begin
            xcnt_q <= xcnt_q + 12'h001;
          end
        end
        default: xs_q <= XF_IDLE;
      endcase
    end
  end

  assign done = (xs_q != XF_IDLE) & (xcnt_q == XFER_LAST);
  assign apply_a = done & (xs_q == XF_WRITE) & (xcmd_q == CMD_WR_CFGA);
  assign apply_b = done & (xs_q == XF_WRITE) & (xcmd_q == CMD_WR_CFGB);

  // Pending auto load, ok flag and data port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_q <= 1'b0;
      ok_q <= 1'b0;
      rdata_q <= 8'h00;
      wbuf_q <= 8'h00;
    end else begin
      if (irq_ev) begin
        pend_q <= 1'b1; // An event in the start cycle queues one more load
      end else if (start_auto) begin
        pend_q <= 1'b0;
      end
      if (dat_wr && xs_q == XF_IDLE) begin
        wbuf_q <= dat_wdata;
      end
      if (done) begin
        ok_q <= 1'b1;
        if (xs_q != XF_WRITE) begin
          rdata_q <= xbuf_q; // RULE1
        end
      end else if (cmd_wr && !start_cmd) begin
        ok_q <= 1'b0; // Refused or unknown command
      end else if (start_cmd || start_auto) begin
        ok_q <= 1'b0;
      end
    end
  end
  assign dat_rdata = rdata_q;
  assign cmd_status = {6'b000000, ok_q, xs_q != XF_IDLE}; // RULE20

  // Configuration lands only when its transfer ends
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_a_q <= CFG_RST;
      cfg_b_q <= CFG_RST;
    end else begin
      if (apply_a) begin
        cfg_a_q <= xbuf_q; // RULE11
      end
      if (apply_b) begin
        cfg_b_q <= xbuf_q; // RULE17
      end
    end
  end

  // Driver enables; only a re-enable write brings them back
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ser_en_q <= 1'b1;
      sec_en_q <= 1'b1;
      wake_en_q <= 1'b1;
    end else begin
      if (th_ev || ser_ev) begin
        ser_en_q <= 1'b0; // RULE5 RULE6
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        ser_en_q <= 1'b1; // RULE16
      end
      if (th_ev) begin
        sec_en_q <= 1'b0; // RULE5
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        sec_en_q <= 1'b1;
      end
      if (th_ev || oc_ev) begin
        wake_en_q <= 1'b0; // RULE5
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        wake_en_q <= 1'b1;
      end
    end
  end

  // Live status; fault bits clear with the re-enable write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live_q <= FLAGS_RST;
    end else begin
      if (th_ev) begin
        live_q[LV_OVERTEMP] <= 1'b1;
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        live_q[LV_OVERTEMP] <= 1'b0;
      end
      if (ser_ev) begin
        live_q[LV_SERIAL_SC] <= 1'b1;
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        live_q[LV_SERIAL_SC] <= 1'b0;
      end
      if (sec_ev) begin
        live_q[LV_SECOND_SC] <= 1'b1;
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        live_q[LV_SECOND_SC] <= 1'b0;
      end
      if (oc_ev) begin
        live_q[LV_WAKE_SC] <= 1'b1; // RULE15
      end else if (apply_b && xbuf_q[CB_REENABLE]) begin
        live_q[LV_WAKE_SC] <= 1'b0;
      end
    end
  end

  // Wake drive request: output mode only, gated by monoflop and faults
  assign wake_on = cfg_a_q[CA_WAKE_ASSERT] & ~timeout_q & wake_en_q & ~cfg_b_q[CB_WAKE_IO]; // RULE10 RULE17

  // Monoflop limits self-heating of the high-side driver
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mono_cnt_q <= 32'h0000_0000;
      timeout_q <= 1'b0;
    end else begin
      if (apply_a) begin
        timeout_q <= 1'b0;
        mono_cnt_q <= 32'h0000_0000;
      end else if (!wake_on || cfg_b_q[CB_MONO_OFF]) begin
        mono_cnt_q <= 32'h0000_0000; // RULE13
      end else if (mono_cnt_q == MONO_CYCLES - 1) begin
        timeout_q <= 1'b1; // RULE12
      end else begin
        mono_cnt_q <= mono_cnt_q + 32'h0000_0001;
      end
    end
  end

  // Overcurrent must persist without a break to count as a short
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oc_cnt_q <= 32'h0000_0000;
    end else if (wake_on && st_q.wake_overcurrent && !oc_ev) begin
      oc_cnt_q <= oc_cnt_q + 32'h0000_0001; // RULE15
    end else begin
      oc_cnt_q <= 32'h0000_0000;
    end
  end

  // Pin drivers from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      drv_q <= '0;
    end else begin
      drv_q.serial_en <= ser_en_q; // RULE5
      drv_q.second_en <= sec_en_q;
      drv_q.wake_out <= 1'b1;
      drv_q.wake_oe <= wake_on; // RULE10
    end
  end
  assign drive = drv_q;

  a_auto_load: assert property (@(posedge clk) disable iff (!arst_n)
    (xs_q == XF_IDLE && pend_q) |=> (xs_q == XF_AUTO && xbuf_q == $past(flags_view))) // RULE1
    else $error("interrupt did not start automatic flag load");
  a_supply_snap: assert property (@(posedge clk) disable iff (!arst_n)
    (start_auto && cfg_a_q[CA_SUPPLY_EN] && st_q.supply_low) |=> xbuf_q[FL_SUPPLY]) // RULE2
    else $error("supply bit missing from snapshot");
  a_wake_edge: assert property (@(posedge clk) disable iff (!arst_n)
    wk_ev |=> flags_q[FL_WAKE_REQ] && hv_irq) // RULE3
    else $error("wake edge not flagged");
  a_thermal_off: assert property (@(posedge clk) disable iff (!arst_n)
    th_ev |=> flags_q[FL_OVERTEMP] ##1 (!drive.serial_en && !drive.second_en && !drive.wake_oe)) // RULE5
    else $error("thermal event left a driver on");
  a_serial_short: assert property (@(posedge clk) disable iff (!arst_n)
    ser_ev |=> flags_q[FL_SERIAL_SC] ##1 !drive.serial_en) // RULE6
    else $error("serial short not handled");
  a_second_short: assert property (@(posedge clk) disable iff (!arst_n)
    sec_ev |=> flags_q[FL_SECOND_SC] && live_q[LV_SECOND_SC]) // RULE7
    else $error("second bus short not flagged");
  a_wake_short: assert property (@(posedge clk) disable iff (!arst_n)
    oc_ev |=> flags_q[FL_WAKE_SC] && live_q[LV_WAKE_SC] && hv_irq ##1 !drive.wake_oe) // RULE15
    else $error("wake overcurrent not handled");
  a_wake_latency: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(drive.wake_oe) |-> $past(apply_a || apply_b, 2)) // RULE11
    else $error("wake output moved without a finished transfer");
  a_mono_expire: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(timeout_q) |-> !cfg_b_q[CB_MONO_OFF] && $past(mono_cnt_q) == MONO_CYCLES - 1) // RULE12
    else $error("monoflop expired at wrong count");
  a_mono_off: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_b_q[CB_MONO_OFF] && !apply_a && !apply_b) |=> !$rose(timeout_q)) // RULE13
    else $error("monoflop expired while disabled");
  a_io_mode: assert property (@(posedge clk) disable iff (!arst_n)
    (cfg_b_q[CB_WAKE_IO] && $past(cfg_b_q[CB_WAKE_IO])) |-> !drive.wake_oe) // RULE17
    else $error("wake driven in input mode");
  a_busy_len: assert property (@(posedge clk) disable iff (!arst_n)
    $fell(cmd_status[ST_BUSY]) |-> $past(xcnt_q) == XFER_LAST && cmd_status[ST_OK]) // RULE20
    else $error("busy ended at wrong count");
endmodule

/* File: tb.sv */
// Self-checking bench for the high-voltage status and wake block.
// Assumes short monoflop and overcurrent counts; each transfer is 2500 cycles.
`timescale 1ns/1ns
module tb;
  import hv_pkg::*;
  localparam int unsigned MONO = 50;
  localparam int unsigned OC = 20;
  typedef struct {
    logic [3:0] fault;
    logic [7:0] auto_exp;
    logic [7:0] live_exp;
    logic [3:0] drv_exp;
    logic [3:0] drv_mask;
  } row_s;
  row_s rows [3] = '{'{4'h1, 8'h02, 8'h02, 4'h8, 4'h8}, '{4'h2, 8'h04, 8'h04, 4'h0, 4'h8},
    '{4'h4, 8'h08, 8'h40, 4'h2, 4'hF}};
  logic clk, arst_n, cmd_wr, dat_wr, hv_irq, gnd_short, ext_en, ext_lvl, oe_seen;
  logic [7:0] cmd_wdata, dat_wdata, cmd_status, dat_rdata;
  logic [3:0] fault;
  hv_sense_s sense;
  hv_drive_s drive;
  int n_fail, checks, n_irq, n0, busy_n, k;

  hv_status_wake #(.MONO_CYCLES(MONO), .OC_CYCLES(OC)) u_dut (.clk(clk), .arst_n(arst_n), .cmd_wr(cmd_wr),
    .cmd_wdata(cmd_wdata), .dat_wr(dat_wr), .dat_wdata(dat_wdata), .cmd_status(cmd_status),
    .dat_rdata(dat_rdata), .sense(sense), .drive(drive), .hv_irq(hv_irq));
  hv_far_side u_far (.drive(drive), .fault(fault), .gnd_short(gnd_short), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .sense(sense));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Interrupt pulses counted, one per cycle high
  always @(negedge clk) if (hv_irq === 1'b1) n_irq++;

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Lets any pending auto load finish so a command is never refused
  task automatic settle();
    int j;
    j = 0;
    tick(40);
    while (cmd_status[ST_BUSY] !== 1'b0 && j < 5000) begin
      tick(1);
      j++;
    end
  endtask
  // One command; optional second command fired mid-transfer must be ignored
  task automatic do_cmd(input logic [7:0] code, input logic [7:0] intrude);
    settle();
    cmd_wdata = code;
    cmd_wr = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    busy_n = 0;
    oe_seen = 1'b0;
    while (cmd_status[ST_BUSY] === 1'b1 && busy_n < 3000) begin
      busy_n++;
      oe_seen |= drive.wake_oe;
      cmd_wr = (busy_n == 5 && intrude != 8'h00);
      cmd_wdata = intrude;
      tick(1);
    end
    check("busy span", busy_n, XFER_CYC);
    check("ok bit", cmd_status[ST_OK], 1'b1);
  endtask
  task automatic wr(input logic [7:0] code, input logic [7:0] val);
    settle();
    dat_wdata = val;
    dat_wr = 1'b1;
    tick(1);
    dat_wr = 1'b0;
    do_cmd(code, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog a little above the roughly 90k-cycle run
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    $display("BAD watchdog expected 0 seen 1");
    tally_and_finish();
  end

  initial begin
    {arst_n, cmd_wr, dat_wr, cmd_wdata, dat_wdata, fault, gnd_short, ext_en, ext_lvl} = '0;
    {n_irq, n_fail, checks} = '0;
    repeat (16) @(posedge clk);
    #1;
    check("status in reset", cmd_status, 8'h00);
    check("data in reset", dat_rdata, 8'h00);
    check("drive in reset", drive, 4'h0);
    arst_n = 1'b1;
    tick(2);
    check("drive after reset", drive, 4'hE);
    do_cmd(CMD_RD_FLAGS, 8'h00);
    check("flags reset", dat_rdata, FLAGS_RST);
    do_cmd(CMD_RD_CFGA, 8'h00);
    check("cfg a reset", dat_rdata, CFG_RST);
    do_cmd(CMD_RD_CFGB, 8'h00);
    check("cfg b reset", dat_rdata, CFG_RST);
    check("no irq", n_irq, 0);
    $display("test reset finished");
    // Fault table: pulse a detector, then auto load, live state and re-enable
    foreach (rows[i]) begin
      n0 = n_irq;
      fault = rows[i].fault;
      tick(10);
      fault = 4'h0;
      settle();
      check("irq raised", n_irq > n0, 1'b1);
      check("auto load", dat_rdata, rows[i].auto_exp);
      check("drivers", drive & rows[i].drv_mask, rows[i].drv_exp);
      do_cmd(CMD_RD_LIVE, 8'h00);
      check("live", dat_rdata, rows[i].live_exp);
      do_cmd(CMD_RD_FLAGS, 8'h00);
      check("flags cleared", dat_rdata, 8'h00);
      wr(CMD_WR_CFGB, 8'h08);
      tick(2);
      check("reenabled", {drive.serial_en, drive.second_en}, 2'h3);
      $display("test fault row %0d finished", i);
    end
    // Supply monitor: masked, then enabled and unlatched
    n0 = n_irq;
    fault = 4'h8;
    do_cmd(CMD_RD_FLAGS, 8'h00);
    check("supply masked irq", n_irq, n0);
    check("supply masked", dat_rdata, 8'h00);
    fault = 4'h0;
    wr(CMD_WR_CFGA, 8'h08);
    fault = 4'h8;
    settle();
    check("supply auto", dat_rdata, 8'h20);
    do_cmd(CMD_RD_FLAGS, 8'h00);
    check("supply live", dat_rdata, 8'h20);
    fault = 4'h0;
    do_cmd(CMD_RD_FLAGS, CMD_RD_LIVE);
    check("supply unlatched", dat_rdata, 8'h00);
    settle();
    cmd_wdata = 8'h55;
    cmd_wr = 1'b1;
    tick(1);
    cmd_wr = 1'b0;
    tick(1);
    check("unknown code", cmd_status, 8'h00);
    wr(CMD_WR_CFGA, 8'h00);
    $display("test supply and refusal finished");
    // Wake output, transfer latency and monoflop
    wr(CMD_WR_CFGA, 8'h10);
    check("wake during xfer", oe_seen, 1'b0);
    check("wake at busy fall", drive.wake_oe, 1'b0);
    tick(2);
    check("wake on", drive.wake_oe, 1'b1);
    k = 0;
    while (drive.wake_oe === 1'b1 && k < 1000) begin
      tick(1);
      k++;
    end
    check("monoflop span", k >= MONO - 1 && k <= MONO + 2, 1'b1);
    tick(20);
    check("stays off", drive.wake_oe, 1'b0);
    wr(CMD_WR_CFGB, 8'h02);
    wr(CMD_WR_CFGA, 8'h10);
    tick(4 * MONO);
    check("no timeout", drive.wake_oe, 1'b1);
    $display("test monoflop finished");
    // Wake overcurrent: a short glitch is ignored, a long one trips
    n0 = n_irq;
    gnd_short = 1'b1;
    tick(OC / 2);
    gnd_short = 1'b0;
    tick(20);
    check("short glitch", n_irq, n0);
    gnd_short = 1'b1;
    settle();
    gnd_short = 1'b0;
    check("oc auto", dat_rdata, 8'h01);
    check("oc off", drive.wake_oe, 1'b0);
    do_cmd(CMD_RD_LIVE, 8'h00);
    check("oc live", dat_rdata, 8'h01);
    wr(CMD_WR_CFGB, 8'h0A);
    tick(3);
    check("wake reenabled", drive.wake_oe, 1'b1);
    wr(CMD_WR_CFGA, 8'h00);
    $display("test overcurrent finished");
    // Input mode: both edges interrupt, live bit follows the pin
    wr(CMD_WR_CFGA, 8'h10);
    wr(CMD_WR_CFGB, 8'h12);
    tick(3);
    check("io output off", drive.wake_oe, 1'b0);
    settle();
    n0 = n_irq;
    ext_en = 1'b1;
    ext_lvl = 1'b1;
    k = 0;
    while (n_irq == n0 && k < 20) begin
      tick(1);
      k++;
    end
    check("edge irq prompt", k <= 8, 1'b1);
    settle();
    check("rise flag", dat_rdata, 8'h10);
    do_cmd(CMD_RD_LIVE, 8'h00);
    check("pin high", dat_rdata, 8'h80);
    n0 = n_irq;
    ext_lvl = 1'b0;
    settle();
    check("fall irq", n_irq > n0, 1'b1);
    check("fall flag", dat_rdata, 8'h10);
    do_cmd(CMD_RD_LIVE, 8'h00);
    check("pin low", dat_rdata, 8'h00);
    $display("test input mode finished");
    tally_and_finish();
  end
endmodule
